// >>> hdl/sfr_guard_pkg.sv
package sfr_guard_pkg;

	// ****************************************
	// Widths
	// ****************************************
	localparam int SFR_ADDR_W = 8;
	localparam int SFR_DATA_W = 8;
	localparam int SEG_W      = 6;
	localparam int SEGMENTS   = 64;
	localparam int HW_GROUPS  = 16;

	// ****************************************
	// Address groups
	// ****************************************
	localparam logic [7:0] GEN_LO    = 8'h80;
	localparam logic [7:0] GEN_HI    = 8'h8F;
	localparam logic [7:0] SYS_LO    = 8'h90;
	localparam logic [7:0] SYS_HI    = 8'h9F;
	localparam logic [7:0] SEGCFG_LO = 8'hA0;
	localparam logic [7:0] SEGCFG_HI = 8'hA7;
	localparam logic [7:0] FW_LO     = 8'hA8;
	localparam logic [7:0] FW_HI     = 8'hAF;
	localparam logic [7:0] POS_LO    = 8'hB0;
	localparam logic [7:0] POS_HI    = 8'hBF;
	localparam logic [7:0] HW_LO     = 8'hC0;

	// ****************************************
	// Special registers
	// ****************************************
	localparam logic [7:0] PSW_HIGH_ADDR      = 8'h90;
	localparam logic [7:0] PROTECT_A_ADDR     = 8'h9E;
	localparam logic [7:0] PROTECT_B_ADDR     = 8'h9F;
	localparam logic [7:0] SEG_PTR_LO_ADDR    = 8'hA0;
	localparam logic [7:0] SEG_PTR_HI_ADDR    = 8'hA1;
	localparam logic [7:0] CLOCK_SELECT_ADDR  = 8'hC0;
	localparam logic [7:0] RANDOM_NUMBER_ADDR = 8'hC1;
	localparam logic [7:0] KEY_A_ADDR         = 8'hC2;
	localparam logic [7:0] KEY_B_ADDR         = 8'hC3;

	// ****************************************
	// Fields and reset values
	// ****************************************
	localparam int          PSW_MODE_LSB   = 0;
	localparam int          HW_INDEX_LSB   = 2;
	localparam logic [1:0]  PSW_MODE_USER  = 2'h0;
	localparam logic [1:0]  PSW_MODE_SYS   = 2'h1;
	localparam logic [1:0]  PSW_MODE_POS   = 2'h2;
	localparam logic [15:0] SEG_PTR_RESET  = 16'h0000;
	localparam logic [7:0]  DENIED_READ    = 8'h00;
	localparam logic [15:0] RIGHTS_RESET   = 16'h0000;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [2:0] {MODE_BOOT, MODE_TEST, MODE_POS, MODE_SYS, MODE_USER} cpu_mode_t;
	typedef enum logic [2:0] {GRP_GENERAL, GRP_SYSMGMT, GRP_SEGCFG, GRP_FIREWALL, GRP_POS, GRP_HW,
		GRP_NONE} sfr_group_t;

	typedef struct packed {
		logic       valid;
		logic       write;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sfr_req_t;

	typedef struct packed {
		logic       boot;
		logic       test;
		logic [7:0] program_status_high;
	} mode_src_t;

	typedef struct packed {
		logic [7:0] firewall_ctrl_high;
		logic [7:0] firewall_ctrl_low;
	} firewall_t;

	typedef struct packed {
		logic             en;
		logic [SEG_W-1:0] index;
		logic [15:0]      rights;
	} rights_wr_t;

	typedef struct packed {
		logic [15:0] seg_ptr;
		logic [7:0]  rdata;
		logic        rvalid;
	} guard_state_t;

	typedef struct packed {
		logic [SEGMENTS-1:0][15:0] table_words;
		logic [15:0]               rd;
	} rights_mem_t;

endpackage

// >>> hdl/segment_rights_table.sv
`timescale 1ns/10ps
module segment_rights_table (
	// Clock and reset
	input  wire logic                       clock_i,
	input  wire logic                       rst_n_i,
	// Write port
	input  wire sfr_guard_pkg::rights_wr_t  wr_i,
	// Read port
	input  wire logic [sfr_guard_pkg::SEG_W-1:0] rd_index_i,
	output logic [15:0]                     rd_rights_o
);
	import sfr_guard_pkg::*;

	rights_mem_t state;
	rights_mem_t next_state;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		next_state = state;
		if (wr_i.en) begin
			next_state.table_words[wr_i.index] = wr_i.rights;
		end
		next_state.rd = state.table_words[rd_index_i];
	end

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			state.table_words <= '0;
			state.rd          <= RIGHTS_RESET;
		end else begin
			state <= next_state;
		end
	end

	assign rd_rights_o = state.rd;

endmodule

// >>> hdl/sfr_access_guard.sv
`timescale 1ns/10ps
module sfr_access_guard (
	// Clock and reset
	input  wire logic                     clock_i,
	input  wire logic                     rst_n_i,
	// CPU access
	input  wire sfr_guard_pkg::sfr_req_t  req_i,
	output logic                          grant_o,
	output logic [7:0]                    rdata_o,
	output logic                          rdata_valid_o,
	// Register file side
	input  wire logic [7:0]               regfile_rdata_i,
	output logic                          reg_wr_o,
	// Mode and rights sources
	input  wire sfr_guard_pkg::mode_src_t mode_src_i,
	input  wire sfr_guard_pkg::firewall_t firewall_i,
	input  wire logic [sfr_guard_pkg::SEG_W-1:0] segment_i,
	input  wire sfr_guard_pkg::rights_wr_t rights_wr_i,
	input  wire logic                     key_a_locked_i,
	// Status
	output sfr_guard_pkg::cpu_mode_t      mode_o,
	output logic [15:0]                   seg_table_ptr_o
);
	import sfr_guard_pkg::*;

	guard_state_t state;
	guard_state_t next_state;
	cpu_mode_t    mode;
	sfr_group_t   grp;
	logic [15:0]  seg_rights;
	logic         allow;
	logic         internal_reg;

	// ****************************************
	// Decoding helpers
	// ****************************************
	function automatic sfr_group_t group_of(input logic [7:0] a);
		sfr_group_t g;
		g = GRP_NONE;
		if (a >= GEN_LO && a <= GEN_HI) begin
			g = GRP_GENERAL;
		end else if (a >= SYS_LO && a <= SYS_HI) begin
			g = GRP_SYSMGMT;
		end else if (a >= SEGCFG_LO && a <= SEGCFG_HI) begin
			g = GRP_SEGCFG;
		end else if (a >= FW_LO && a <= FW_HI) begin
			g = GRP_FIREWALL;
		end else if (a >= POS_LO && a <= POS_HI) begin
			g = GRP_POS;
		end else if (a >= HW_LO) begin
			g = GRP_HW;
		end
		return g;
	endfunction

	function automatic cpu_mode_t mode_of(input mode_src_t s);
		cpu_mode_t m;
		m = MODE_USER;
		if (s.boot) begin
			m = MODE_BOOT;
		end else if (s.test) begin
			m = MODE_TEST;
		end else begin
			case (s.program_status_high[PSW_MODE_LSB +: 2])
				PSW_MODE_SYS: m = MODE_SYS;
				PSW_MODE_POS: m = MODE_POS;
				default:      m = MODE_USER;
			endcase
		end
		return m;
	endfunction

	function automatic logic hw_bit(input logic [15:0] rights, input logic [7:0] a);
		return rights[a[HW_INDEX_LSB +: 4]];
	endfunction

	function automatic logic decide(input cpu_mode_t m, input sfr_group_t g, input logic [7:0] a,
		input logic wr, input logic [15:0] fw, input logic [15:0] seg, input logic ptr_ok,
		input logic key_lock);
		logic ok;
		ok = 1'b0;
		case (m)
			MODE_BOOT, MODE_TEST: begin
				ok = (g != GRP_NONE);
			end
			MODE_POS: begin
				case (g)
					GRP_FIREWALL: ok = !wr;
					GRP_POS:      ok = 1'b1;
					GRP_HW:       ok = hw_bit(fw, a) || (!wr && a == CLOCK_SELECT_ADDR);
					GRP_SYSMGMT:  ok = !wr && a == PSW_HIGH_ADDR;
					default:      ok = 1'b0;
				endcase
			end
			MODE_SYS: begin
				ok = (g == GRP_SEGCFG) || (g == GRP_SYSMGMT) || (g == GRP_FIREWALL) || (g == GRP_HW);
			end
			MODE_USER: begin
				case (g)
					GRP_HW:      ok = ptr_ok && hw_bit(seg, a);
					GRP_SYSMGMT: ok = !wr && a == PSW_HIGH_ADDR;
					default:     ok = 1'b0;
				endcase
			end
			default: ok = 1'b0;
		endcase
		if (g == GRP_GENERAL) begin
			ok = 1'b1;
		end
		if (g == GRP_SEGCFG && m != MODE_SYS) begin
			ok = 1'b0;
		end
		if (!wr && (a == PROTECT_A_ADDR || a == PROTECT_B_ADDR)) begin
			ok = 1'b0;
		end
		if (wr && a == RANDOM_NUMBER_ADDR) begin
			ok = 1'b0;
		end
		if (!wr && (a == KEY_A_ADDR || a == KEY_B_ADDR)) begin
			ok = 1'b0;
		end
		if (key_lock && a == KEY_A_ADDR) begin
			ok = 1'b0;
		end
		return ok;
	endfunction

	// ****************************************
	// Current segment rights
	// ****************************************
	segment_rights_table u_segment_rights_table (
		.clock_i     (clock_i),
		.rst_n_i     (rst_n_i),
		.wr_i        (rights_wr_i),
		.rd_index_i  (segment_i),
		.rd_rights_o (seg_rights)
	);

	// ****************************************
	// Grant decision
	// ****************************************
	assign mode         = mode_of(mode_src_i);
	assign grp          = group_of(req_i.addr);
	assign internal_reg = (req_i.addr == SEG_PTR_LO_ADDR) || (req_i.addr == SEG_PTR_HI_ADDR);
	assign allow        = decide(mode, grp, req_i.addr, req_i.write, firewall_i, seg_rights,
		state.seg_ptr != SEG_PTR_RESET, key_a_locked_i);

	assign grant_o  = req_i.valid && allow;
	assign reg_wr_o = req_i.valid && req_i.write && allow && !internal_reg;

	// ****************************************
	// State update
	// ****************************************
	always_comb begin
		next_state        = state;
		next_state.rvalid = req_i.valid && !req_i.write;
		if (req_i.valid && !req_i.write) begin
			if (!allow) begin
				next_state.rdata = DENIED_READ;
			end else if (req_i.addr == SEG_PTR_LO_ADDR) begin
				next_state.rdata = state.seg_ptr[7:0];
			end else if (req_i.addr == SEG_PTR_HI_ADDR) begin
				next_state.rdata = state.seg_ptr[15:8];
			end else begin
				next_state.rdata = regfile_rdata_i;
			end
		end
		if (req_i.valid && req_i.write && allow) begin
			if (req_i.addr == SEG_PTR_LO_ADDR) begin
				next_state.seg_ptr[7:0] = req_i.wdata;
			end else if (req_i.addr == SEG_PTR_HI_ADDR) begin
				next_state.seg_ptr[15:8] = req_i.wdata;
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			state.seg_ptr <= SEG_PTR_RESET;
			state.rdata   <= DENIED_READ;
			state.rvalid  <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	assign rdata_o         = state.rdata;
	assign rdata_valid_o   = state.rvalid;
	assign seg_table_ptr_o = state.seg_ptr;
	assign mode_o          = mode;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);

	logic rd_req;
	logic wr_req;
	logic hw_plain;
	assign rd_req   = req_i.valid && !req_i.write;
	assign wr_req   = req_i.valid && req_i.write;
	assign hw_plain = grp == GRP_HW && req_i.addr > KEY_B_ADDR;

	a_denied_read_zero: assert property (rd_req && !grant_o |=> rdata_valid_o && rdata_o == 8'h00)
		else $error("denied read did not return zero");
	a_denied_write_drop: assert property (wr_req && !grant_o && internal_reg |=> $stable(seg_table_ptr_o))
		else $error("denied write changed pointer");
	a_boot_full: assert property (mode == MODE_BOOT && req_i.valid && hw_plain
		|-> grant_o && (reg_wr_o == req_i.write))
		else $error("boot access refused");
	a_test_full: assert property (mode == MODE_TEST && req_i.valid && grp == GRP_POS |-> grant_o)
		else $error("test access refused");
	a_pos_fw_ro: assert property (mode == MODE_POS && grp == GRP_FIREWALL |-> grant_o == rd_req)
		else $error("firewall group not read-only");
	a_pos_hw_fw: assert property (mode == MODE_POS && req_i.valid && hw_plain
		|-> grant_o == hw_bit(firewall_i, req_i.addr))
		else $error("firewall right not followed");
	a_sys_access: assert property (mode == MODE_SYS && wr_req && req_i.addr == SEG_PTR_HI_ADDR
		|=> seg_table_ptr_o[15:8] == $past(req_i.wdata))
		else $error("system pointer write lost");
	a_user_rights: assert property (mode == MODE_USER && req_i.valid && hw_plain
		&& seg_table_ptr_o == 16'h0000 |-> !grant_o)
		else $error("user access with null table");
	a_general_open: assert property (req_i.valid && grp == GRP_GENERAL |-> grant_o)
		else $error("general register refused");
	a_psw_read: assert property ((mode == MODE_USER || mode == MODE_POS) && rd_req
		&& req_i.addr == PSW_HIGH_ADDR |-> grant_o)
		else $error("status high read refused");
	a_clock_sel_read: assert property (mode == MODE_POS && rd_req && req_i.addr == CLOCK_SELECT_ADDR |-> grant_o)
		else $error("clock select read refused");
	a_segcfg_deny: assert property (mode != MODE_SYS && grp == GRP_SEGCFG |-> !grant_o)
		else $error("segmentation access outside system mode");
	a_protect_hidden: assert property (rd_req
		&& (req_i.addr == PROTECT_A_ADDR || req_i.addr == PROTECT_B_ADDR) |-> !grant_o)
		else $error("protection register read");
	a_random_ro: assert property (wr_req && req_i.addr == RANDOM_NUMBER_ADDR |-> !reg_wr_o)
		else $error("random register written");
	a_key_hidden: assert property (rd_req && (req_i.addr == KEY_A_ADDR || req_i.addr == KEY_B_ADDR)
		|=> rdata_o == 8'h00)
		else $error("key register read");
	a_key_locked: assert property (key_a_locked_i && req_i.addr == KEY_A_ADDR |-> !grant_o)
		else $error("locked key reached");
	a_mode_decode: assert property (!mode_src_i.boot && !mode_src_i.test
		&& mode_src_i.program_status_high[1:0] == 2'h1 |-> mode_o == MODE_SYS)
		else $error("mode decode wrong");
	a_unmapped_deny: assert property (req_i.valid && req_i.addr < GEN_LO
		|-> !grant_o ##1 ($past(req_i.write) || rdata_o == DENIED_READ))
		else $error("unmapped access granted");

	a_wr_strobe_gated: assert property (reg_wr_o |-> grant_o && req_i.write && !internal_reg)
		else $error("write strobe without grant");
	a_rvalid_follows: assert property (rd_req |=> rdata_valid_o)
		else $error("read answer missing");
	a_rvalid_idle: assert property (!rd_req |=> !rdata_valid_o)
		else $error("read answer without read");
	a_read_data_pass: assert property (rd_req && grant_o && !internal_reg
		|=> rdata_o == $past(regfile_rdata_i))
		else $error("granted read data lost");
	a_pos_own_group: assert property (mode == MODE_POS && req_i.valid && grp == GRP_POS |-> grant_o)
		else $error("protected-OS group refused");
	a_sys_group_open: assert property (mode == MODE_SYS && req_i.valid && (grp == GRP_FIREWALL || hw_plain)
		|-> grant_o)
		else $error("system mode access refused");
	a_sys_pos_deny: assert property (mode == MODE_SYS && req_i.valid && grp == GRP_POS |-> !grant_o)
		else $error("protected-OS group reached from system mode");
	a_user_group_deny: assert property (mode == MODE_USER && req_i.valid
		&& (grp == GRP_FIREWALL || grp == GRP_POS) |-> !grant_o)
		else $error("user reached a closed group");
	a_user_hw_rights: assert property (mode == MODE_USER && req_i.valid && hw_plain
		&& seg_table_ptr_o != SEG_PTR_RESET |-> grant_o == hw_bit(seg_rights, req_i.addr))
		else $error("segment right not followed");
	a_boot_priority: assert property (mode_src_i.boot |-> mode_o == MODE_BOOT)
		else $error("boot bit not decoded");

	property p_reset_ptr;
		@(posedge clock_i) disable iff (1'b0) !rst_n_i |=> seg_table_ptr_o == SEG_PTR_RESET;
	endproperty
	a_reset_ptr: assert property (p_reset_ptr)
		else $error("pointer not cleared by reset");

	// ****************************************
	// Coverage
	// ****************************************
	c_user_grant: cover property (mode == MODE_USER && grant_o && grp == GRP_HW);
	c_pos_clock_sel: cover property (mode == MODE_POS && rd_req && req_i.addr == CLOCK_SELECT_ADDR
		&& !hw_bit(firewall_i, req_i.addr));
	c_sys_ptr_write: cover property (mode == MODE_SYS && wr_req && internal_reg ##1 seg_table_ptr_o != 16'h0000);
	c_key_denied: cover property (rd_req && req_i.addr == KEY_A_ADDR && !grant_o);
	c_user_null_table: cover property (mode == MODE_USER && req_i.valid && hw_plain && seg_table_ptr_o == SEG_PTR_RESET);

endmodule

// >>> test/sfr_regfile_model.sv
`timescale 1ns/10ps
module sfr_regfile_model (
	// Clock
	input  wire logic                    clock_i,
	// Access from the guard side
	input  wire sfr_guard_pkg::sfr_req_t req_i,
	input  wire logic                    reg_wr_i,
	output logic [7:0]                   rdata_o
);
	import sfr_guard_pkg::*;

	logic [7:0] mem [256];

	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'(i) ^ 8'hA5;
		end
	end

	// Idle bus shows inverted data so stale values never pass
	assign rdata_o = req_i.valid ? mem[req_i.addr] : ~mem[req_i.addr];

	always @(posedge clock_i) begin
		if (reg_wr_i) begin
			mem[req_i.addr] <= req_i.wdata;
		end
	end
endmodule

// >>> test/sfr_access_guard_tb.sv
`timescale 1ns/10ps
module sfr_access_guard_tb;
	import sfr_guard_pkg::*;

	// ****************************************
	// Signals
	// ****************************************
	localparam logic [7:0] SPEC [16] = '{8'h80, 8'h8F, 8'h90, 8'h9E, 8'h9F, 8'hA0, 8'hA1, 8'hA7,
		8'hA8, 8'hAF, 8'hB0, 8'hBF, 8'hC0, 8'hC1, 8'hC2, 8'hC3};
	logic             clock_i        = 1'b0;
	logic             rst_n_i        = 1'b0;
	logic             key_a_locked_i = 1'b0;
	sfr_req_t         req_i          = '0;
	mode_src_t        mode_src_i     = '0;
	firewall_t        firewall_i     = '0;
	rights_wr_t       rights_wr_i    = '0;
	logic [SEG_W-1:0] segment_i      = '0;
	logic             grant_o;
	logic             rdata_valid_o;
	logic             reg_wr_o;
	logic [7:0]       rdata_o;
	logic [7:0]       regfile_rdata_i;
	cpu_mode_t        mode_o;
	logic [15:0]      seg_table_ptr_o;
	int               num_errors     = 0;
	int               cmp_count      = 0;
	int               cycles         = 0;
	logic [31:0]      seed           = 32'hE848;
	logic [15:0]      ptr            = 16'h0000;
	logic [7:0]       shadow [256];
	logic [15:0]      rights [SEGMENTS];
	logic [7:0]       exp_q [$];

	always #20 clock_i = ~clock_i;

	sfr_access_guard u_sfr_access_guard (
		.clock_i(clock_i), .rst_n_i(rst_n_i), .req_i(req_i), .grant_o(grant_o), .rdata_o(rdata_o),
		.rdata_valid_o(rdata_valid_o), .regfile_rdata_i(regfile_rdata_i), .reg_wr_o(reg_wr_o),
		.mode_src_i(mode_src_i), .firewall_i(firewall_i), .segment_i(segment_i),
		.rights_wr_i(rights_wr_i), .key_a_locked_i(key_a_locked_i), .mode_o(mode_o),
		.seg_table_ptr_o(seg_table_ptr_o)
	);

	sfr_regfile_model u_sfr_regfile_model (
		.clock_i(clock_i), .req_i(req_i), .reg_wr_i(reg_wr_o), .rdata_o(regfile_rdata_i)
	);

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] lfsr_next();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	function automatic cpu_mode_t exp_mode();
		if (mode_src_i.boot) return MODE_BOOT;
		if (mode_src_i.test) return MODE_TEST;
		case (mode_src_i.program_status_high[1:0])
			2'h1: return MODE_SYS;
			2'h2: return MODE_POS;
			default: return MODE_USER;
		endcase
	endfunction

	function automatic logic allowed(input logic wr, input logic [7:0] a);
		cpu_mode_t   m;
		logic [15:0] fw;
		m = exp_mode();
		fw = firewall_i;
		if (a < 8'h80) return 1'b0;
		if (a >= 8'hA0 && a <= 8'hA7) return m == MODE_SYS;
		if (!wr && (a == 8'h9E || a == 8'h9F || a == 8'hC2 || a == 8'hC3)) return 1'b0;
		if (wr && a == 8'hC1) return 1'b0;
		if (key_a_locked_i && a == 8'hC2) return 1'b0;
		if (a <= 8'h8F || m == MODE_BOOT || m == MODE_TEST) return 1'b1;
		if (!wr && a == 8'h90 && m != MODE_SYS) return 1'b1;
		if (m == MODE_SYS) return a < 8'hB0 || a >= 8'hC0;
		if (m == MODE_POS) begin
			if (a >= 8'hA8 && a <= 8'hAF) return !wr;
			if (a >= 8'hB0 && a <= 8'hBF) return 1'b1;
			return a >= 8'hC0 && (fw[a[5:2]] || (!wr && a == 8'hC0));
		end
		return a >= 8'hC0 && ptr != 16'h0000 && rights[segment_i][a[5:2]];
	endfunction

	task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
		logic ok;
		@(negedge clock_i);
		req_i = {1'b1, wr, a, d};
		ok = allowed(wr, a);
		#5;
		check(16'(grant_o), 16'(ok));
		check(16'(reg_wr_o), 16'(ok && wr && a != 8'hA0 && a != 8'hA1));
		if (!wr) exp_q.push_back(!ok ? 8'h00 : a == 8'hA0 ? ptr[7:0] : a == 8'hA1 ? ptr[15:8] : shadow[a]);
		else if (ok && a == 8'hA0) ptr[7:0] = d;
		else if (ok && a == 8'hA1) ptr[15:8] = d;
		else if (ok) shadow[a] = d;
	endtask

	// ****************************************
	// Monitor and timeout
	// ****************************************
	always @(posedge clock_i) begin
		#1;
		if (rdata_valid_o === 1'b1) begin
			if (exp_q.size() == 0) check(16'h0001, 16'h0000);
			else check(16'(rdata_o), 16'(exp_q.pop_front()));
		end
	end

	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			summarize();
		end
	end

	// ****************************************
	// Stimulus
	// ****************************************
	initial begin
		logic [31:0] r;
		for (int i = 0; i < 256; i++) begin
			shadow[i] = 8'(i) ^ 8'hA5;
		end
		repeat (16) @(negedge clock_i);
		rst_n_i = 1'b1;
		#5;
		check(seg_table_ptr_o, 16'h0000);
		for (int s = 0; s < SEGMENTS; s++) begin
			@(negedge clock_i);
			r = lfsr_next();
			rights[s] = r[15:0];
			rights_wr_i = {1'b1, 6'(s), r[15:0]};
		end
		for (int b = 0; b < 100; b++) begin
			@(negedge clock_i);
			r = lfsr_next();
			req_i.valid = 1'b0;
			rights_wr_i.en = 1'b0;
			mode_src_i = {r[0] & r[1] & r[2], r[3] & r[4] & r[5], 6'h00, r[7:6]};
			firewall_i = r[23:8];
			segment_i = r[29:24];
			key_a_locked_i = r[30];
			#5;
			check(16'(mode_o), 16'(exp_mode()));
			check(seg_table_ptr_o, ptr);
			@(negedge clock_i);
			repeat (16) begin
				r = lfsr_next();
				access(r[0], r[1] ? {1'b1, r[14:8]} : r[2] ? r[15:8] : SPEC[r[11:8]], r[23:16]);
			end
		end
		@(negedge clock_i);
		req_i.valid = 1'b0;
		repeat (2) @(negedge clock_i);
		check(16'(exp_q.size()), 16'h0000);
		summarize();
	end
endmodule
